// *** core/sine_seq_pkg.sv ***
package sine_seq_pkg;

	// ------------------------------------------------------------------
	// Widths and table geometry
	// ------------------------------------------------------------------
	localparam int CODE_W = 12;
	localparam int IDX_W = 5;
	localparam logic [4:0] TABLE_LAST = 5'h17;
	localparam logic [11:0] CODE_RESET = 12'h800;
	localparam int FIFO_DEPTH = 4;

	// ------------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------------
	localparam logic [2:0] WAVE_SINE = 3'h4;
	localparam logic [2:0] WAVE_RESET = 3'h0;
	localparam logic [3:0] STEP_RESET = 4'h0;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam logic [2:0] GAIN_RESET = 3'h0;
	localparam logic [1:0] TRIG_RESET = 2'h0;
	localparam logic [1:0] TRIG_START_STOP = 2'h1;
	localparam logic SDO_RESET = 1'b1;

	// Phase encodings and the table index each one starts from.
	localparam logic [1:0] PHASE_0 = 2'h0;
	localparam logic [1:0] PHASE_120 = 2'h1;
	localparam logic [1:0] PHASE_240 = 2'h2;
	localparam logic [1:0] PHASE_90 = 2'h3;
	localparam logic [4:0] START_IDX_0 = 5'h00;
	localparam logic [4:0] START_IDX_90 = 5'h06;
	localparam logic [4:0] START_IDX_120 = 5'h08;
	localparam logic [4:0] START_IDX_240 = 5'h10;

	// Gain encodings: first two use a unity stage, the rest the internal reference.
	localparam logic [2:0] GAIN_X1_EXT = 3'h0;
	localparam logic [2:0] GAIN_X1_VDD = 3'h1;
	localparam logic [2:0] GAIN_X1P5 = 3'h2;
	localparam logic [2:0] GAIN_X2 = 3'h3;
	localparam logic [2:0] GAIN_X3 = 3'h4;
	localparam logic [2:0] GAIN_X4 = 3'h5;

	// Packed settings image: {wave, step, phase, gain, trig, sdo}.
	localparam int SET_W = 15;
	localparam int SET_WAVE_LSB = 12;
	localparam int SET_STEP_LSB = 8;
	localparam int SET_PHASE_LSB = 6;
	localparam int SET_GAIN_LSB = 3;
	localparam int SET_TRIG_LSB = 1;
	localparam int SET_SDO_LSB = 0;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int STEP_UNIT_NS = 1000;
	localparam int STEP_UNIT_CYC = (STEP_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0] UNIT_LAST = 8'(STEP_UNIT_CYC - 1);

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;

endpackage

// *** core/sine_code_table.sv ***
`timescale 1ns/100ps
module sine_code_table (
	input wire logic [4:0] idx, // Table index, 0 to 23
	output logic [11:0] code // Output code at that index
);
	always_comb begin
		case (idx)
			5'h00: code = 12'h800;
			5'h01: code = 12'h9a8;
			5'h02: code = 12'hb33;
			5'h03: code = 12'hc87;
			5'h04: code = 12'hd8b;
			5'h05: code = 12'he2f;
			5'h06: code = 12'he66;
			5'h07: code = 12'he2f;
			5'h08: code = 12'hd8b;
			5'h09: code = 12'hc87;
			5'h0a: code = 12'hb33;
			5'h0b: code = 12'h9a8;
			5'h0c: code = 12'h800;
			5'h0d: code = 12'h658;
			5'h0e: code = 12'h4cd;
			5'h0f: code = 12'h379;
			5'h10: code = 12'h275;
			5'h11: code = 12'h1d1;
			5'h12: code = 12'h19a;
			5'h13: code = 12'h1d1;
			5'h14: code = 12'h275;
			5'h15: code = 12'h379;
			5'h16: code = 12'h4cd;
			5'h17: code = 12'h658;
			default: code = 12'h800;
		endcase
	end
endmodule

// *** core/code_fifo.sv ***
`timescale 1ns/100ps
module code_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic flush, // Drop all entries
	input wire logic in_valid, // Write request
	output logic in_ready, // Space available
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Entry available
	input wire logic out_ready, // Read accept
	output logic [WIDTH-1:0] out_data // Head entry
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (flush) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end else begin
			if (push) begin
				wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// The storage itself needs no reset; empty is tracked by the count.
	always_ff @(posedge clk) begin
		if (push && !flush) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule

// *** core/sine_wave_code_sequencer.sv ***
//
// Overview of operation
// RULE_01 - Active sine cycles 24 codes, then wraps.
// RULE_02 - Fixed symmetric 12-bit table, peak index 6.
// RULE_03 - Waveform select 100 enables sine generation.
// RULE_04 - Each entry held one step interval.
// RULE_05 - Gain select picks reference and amplitude.
// RULE_06 - Two-bit start phase field, four phases.
// RULE_07 - Start index 0, 6, 8 or 16.
// RULE_08 - Configured trigger pin rising edge starts.
// RULE_09 - Trigger pin both starts and halts.
// RULE_10 - Host disables serial output before trigger use.
// RULE_11 - Store command saves settings to NVM.
// RULE_12 - Reset reloads settings from programmed NVM.
// RULE_13 - Host writes configuration over I2C or SPI.
// RULE_14 - Phase codes: 0, 120, 240, 90 degrees.
// RULE_15 - Trigger low halts, holds start-phase code.
//
`timescale 1ns/100ps
module sine_wave_code_sequencer (
	input wire logic mclk, // System clock, 200 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic cfg_wr, // One-cycle write strobe from the host link decoder
	input wire logic [2:0] cfg_waveform_select, // Waveform select value
	input wire logic [3:0] cfg_step_interval, // Step interval code
	input wire logic [1:0] cfg_start_phase_select, // Start phase code
	input wire logic [2:0] cfg_output_gain_select, // Gain and reference code
	input wire logic [1:0] cfg_trigger_pin_setup, // Pin function code
	input wire logic cfg_serial_out_enable, // Serial data output on shared pin
	input wire logic nvm_store_trigger, // One-cycle store command
	input wire logic nvm_programmed, // Non-volatile image is valid
	input wire logic [14:0] nvm_rd_data, // Stored settings image
	output logic nvm_wr_en, // One-cycle store pulse to the NVM
	output logic [14:0] nvm_wr_data, // Settings image to store
	input wire logic trigger_input, // Asynchronous general-purpose pin
	input wire logic dac_load_ready, // Output latch can take a code
	output logic [11:0] dac_code, // Code loaded into the output latch
	output logic dac_update, // One-cycle pulse, new code loaded
	output logic [2:0] gain_code, // Active gain code to the output stage
	output logic int_ref_enable, // Internal reference in use
	output logic [14:0] settings, // Current settings image, readback
	output logic running, // Sequence is stepping
	output logic [4:0] table_index // Index of the current code, queued or still pending
);

	// ------------------------------------------------------------------
	// Settings registers
	// ------------------------------------------------------------------
	logic [2:0] wave_q, wave_d;
	logic [3:0] step_q, step_d;
	logic [1:0] phase_q, phase_d;
	logic [2:0] gain_q, gain_d;
	logic [1:0] trig_q, trig_d;
	logic sdo_q, sdo_d;
	logic nvm_wr_q, nvm_wr_d;
	logic [14:0] nvm_data_q, nvm_data_d;
	sine_seq_pkg::seq_state_t state_q, state_d;
	logic [14:0] image;

	assign image = {wave_q, step_q, phase_q, gain_q, trig_q, sdo_q};

	always_comb begin
		wave_d = wave_q;
		step_d = step_q;
		phase_d = phase_q;
		gain_d = gain_q;
		trig_d = trig_q;
		sdo_d = sdo_q;
		nvm_wr_d = 1'b0;
		nvm_data_d = nvm_data_q;
		if (state_q == sine_seq_pkg::ST_LOAD) begin
			if (nvm_programmed) begin
				wave_d = nvm_rd_data[sine_seq_pkg::SET_WAVE_LSB +: 3]; // RULE_12
				step_d = nvm_rd_data[sine_seq_pkg::SET_STEP_LSB +: 4]; // RULE_12
				phase_d = nvm_rd_data[sine_seq_pkg::SET_PHASE_LSB +: 2]; // RULE_12
				gain_d = nvm_rd_data[sine_seq_pkg::SET_GAIN_LSB +: 3]; // RULE_12
				trig_d = nvm_rd_data[sine_seq_pkg::SET_TRIG_LSB +: 2]; // RULE_12
				sdo_d = nvm_rd_data[sine_seq_pkg::SET_SDO_LSB]; // RULE_12
			end
		end else if (cfg_wr) begin
			wave_d = cfg_waveform_select; // RULE_13
			step_d = cfg_step_interval; // RULE_13
			phase_d = cfg_start_phase_select; // RULE_13
			gain_d = cfg_output_gain_select; // RULE_13
			trig_d = cfg_trigger_pin_setup; // RULE_13
			sdo_d = cfg_serial_out_enable; // RULE_13
		end
		// A store issued with a write in the same cycle saves the settings
		// as they stood before that write.
		if (nvm_store_trigger && state_q != sine_seq_pkg::ST_LOAD) begin
			nvm_wr_d = 1'b1; // RULE_11
			nvm_data_d = image; // RULE_11
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wave_q <= sine_seq_pkg::WAVE_RESET;
			step_q <= sine_seq_pkg::STEP_RESET;
			phase_q <= sine_seq_pkg::PHASE_RESET;
			gain_q <= sine_seq_pkg::GAIN_RESET;
			trig_q <= sine_seq_pkg::TRIG_RESET;
			sdo_q <= sine_seq_pkg::SDO_RESET;
			nvm_wr_q <= 1'b0;
			nvm_data_q <= '0;
		end else begin
			wave_q <= wave_d;
			step_q <= step_d;
			phase_q <= phase_d;
			gain_q <= gain_d;
			trig_q <= trig_d;
			sdo_q <= sdo_d;
			nvm_wr_q <= nvm_wr_d;
			nvm_data_q <= nvm_data_d;
		end
	end

	assign nvm_wr_en = nvm_wr_q;
	assign nvm_wr_data = nvm_data_q;
	assign settings = image;

	// ------------------------------------------------------------------
	// Trigger pin synchroniser and mode decode
	// ------------------------------------------------------------------
	logic pin_meta_q, pin_sync_q, pin_prev_q;
	logic trig_mode, pin_rise, pin_low, sine_on;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= trigger_input;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// The shared pin is only a trigger once its serial output is off; a
	// pin still driving serial data would otherwise start the sequence.
	assign trig_mode = (trig_q == sine_seq_pkg::TRIG_START_STOP) && !sdo_q; // RULE_10
	assign pin_rise = pin_sync_q && !pin_prev_q; // RULE_08
	assign pin_low = !pin_sync_q; // RULE_09
	assign sine_on = (wave_q == sine_seq_pkg::WAVE_SINE); // RULE_03

	// ------------------------------------------------------------------
	// Phase to start index
	// ------------------------------------------------------------------
	logic [4:0] start_idx;

	always_comb begin
		case (phase_q) // RULE_06
			sine_seq_pkg::PHASE_0: start_idx = sine_seq_pkg::START_IDX_0; // RULE_14
			sine_seq_pkg::PHASE_120: start_idx = sine_seq_pkg::START_IDX_120; // RULE_07
			sine_seq_pkg::PHASE_240: start_idx = sine_seq_pkg::START_IDX_240; // RULE_07
			sine_seq_pkg::PHASE_90: start_idx = sine_seq_pkg::START_IDX_90; // RULE_07
			default: start_idx = sine_seq_pkg::START_IDX_0;
		endcase
	end

	// ------------------------------------------------------------------
	// Step timebase
	// ------------------------------------------------------------------
	logic [7:0] unit_q, unit_d;
	logic [3:0] units_q, units_d;
	logic unit_tick, step_done;

	// Fifo and table wiring used by the sequencer below.
	logic fifo_in_ready, fifo_in_valid, fifo_flush;
	logic fifo_out_valid;
	logic [11:0] table_code, fifo_out_data;
	logic [4:0] idx_q, idx_d;
	logic pend_q, pend_d;
	logic push;

	assign push = fifo_in_valid && fifo_in_ready;
	assign unit_tick = (unit_q == sine_seq_pkg::UNIT_LAST);
	assign step_done = unit_tick && (units_q == step_q); // RULE_04

	// The interval only counts once the current code has been queued, so
	// back-pressure from the output latch stretches a step, never drops one.
	// Counting starts in the push cycle itself, so a step lasts the interval exactly.
	always_comb begin
		unit_d = unit_q;
		units_d = units_q;
		if (state_q != sine_seq_pkg::ST_RUN || (pend_q && !push)) begin
			unit_d = '0;
			units_d = '0;
		end else if (unit_tick) begin
			unit_d = '0;
			units_d = step_done ? 4'h0 : units_q + 4'h1; // RULE_04
		end else begin
			unit_d = unit_q + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			unit_q <= '0;
			units_q <= '0;
		end else begin
			unit_q <= unit_d;
			units_q <= units_d;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		pend_d = pend_q && !push;
		fifo_flush = 1'b0;
		case (state_q)
			sine_seq_pkg::ST_LOAD: begin
				state_d = sine_seq_pkg::ST_IDLE; // RULE_12
				idx_d = sine_seq_pkg::START_IDX_0;
				pend_d = 1'b0;
			end
			sine_seq_pkg::ST_IDLE: begin
				if (!sine_on) begin
					pend_d = 1'b0;
				end else if (!trig_mode || pin_rise) begin
					state_d = sine_seq_pkg::ST_RUN; // RULE_08
					idx_d = start_idx; // RULE_07
					pend_d = 1'b1;
					fifo_flush = 1'b1;
				end else if (idx_q != start_idx && !pend_q) begin
					idx_d = start_idx; // RULE_15
					pend_d = 1'b1;
				end
			end
			sine_seq_pkg::ST_RUN: begin
				if (!sine_on) begin
					state_d = sine_seq_pkg::ST_IDLE; // RULE_03
					pend_d = 1'b0;
				end else if (trig_mode && pin_low) begin
					state_d = sine_seq_pkg::ST_IDLE; // RULE_09
					idx_d = start_idx; // RULE_15
					pend_d = 1'b1;
					fifo_flush = 1'b1;
				end else if (step_done) begin
					idx_d = (idx_q == sine_seq_pkg::TABLE_LAST) ? 5'h00 : idx_q + 5'h01; // RULE_01
					pend_d = 1'b1;
				end
			end
			default: begin
				state_d = sine_seq_pkg::ST_IDLE;
				pend_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= sine_seq_pkg::ST_LOAD;
			idx_q <= '0;
			pend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			pend_q <= pend_d;
		end
	end

	assign fifo_in_valid = pend_q && !fifo_flush;
	assign running = (state_q == sine_seq_pkg::ST_RUN);
	assign table_index = idx_q;

	sine_code_table u_table (
		.idx(idx_q),
		.code(table_code) // RULE_02
	);

	code_fifo #(
		.WIDTH(sine_seq_pkg::CODE_W),
		.DEPTH(sine_seq_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.rst_n(rst_n),
		.flush(fifo_flush),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(table_code),
		.out_valid(fifo_out_valid),
		.out_ready(dac_load_ready),
		.out_data(fifo_out_data)
	);

	// ------------------------------------------------------------------
	// Output latch and gain
	// ------------------------------------------------------------------
	logic [11:0] code_q, code_d;
	logic upd_q, upd_d;
	logic [2:0] gcode_q, gcode_d;
	logic iref_q, iref_d;

	always_comb begin
		code_d = code_q;
		upd_d = 1'b0;
		if (fifo_out_valid && dac_load_ready) begin
			code_d = fifo_out_data;
			upd_d = 1'b1;
		end
		gcode_d = gain_q; // RULE_05
		case (gain_q)
			sine_seq_pkg::GAIN_X1_EXT, sine_seq_pkg::GAIN_X1_VDD: iref_d = 1'b0; // RULE_05
			sine_seq_pkg::GAIN_X1P5, sine_seq_pkg::GAIN_X2: iref_d = 1'b1; // RULE_05
			sine_seq_pkg::GAIN_X3, sine_seq_pkg::GAIN_X4: iref_d = 1'b1; // RULE_05
			default: begin
				iref_d = 1'b0;
				gcode_d = sine_seq_pkg::GAIN_X1_EXT;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			code_q <= sine_seq_pkg::CODE_RESET;
			upd_q <= 1'b0;
			gcode_q <= sine_seq_pkg::GAIN_RESET;
			iref_q <= 1'b0;
		end else begin
			code_q <= code_d;
			upd_q <= upd_d;
			gcode_q <= gcode_d;
			iref_q <= iref_d;
		end
	end

	assign dac_code = code_q;
	assign dac_update = upd_q;
	assign gain_code = gcode_q;
	assign int_ref_enable = iref_q;

endmodule

// *** tb/seq_checker.sv ***
`timescale 1ns/100ps
module seq_checker (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic cfg_wr, // Write strobe
	input wire logic [2:0] cfg_waveform_select, // Waveform
	input wire logic [3:0] cfg_step_interval, // Step
	input wire logic [1:0] cfg_start_phase_select, // Phase
	input wire logic [2:0] cfg_output_gain_select, // Gain
	input wire logic [1:0] cfg_trigger_pin_setup, // Pin use
	input wire logic cfg_serial_out_enable, // Serial out
	input wire logic nvm_store_trigger, // Store
	input wire logic nvm_wr_en, // Store pulse
	input wire logic [14:0] nvm_wr_data, // Stored image
	input wire logic trigger_input, // Pin
	input wire logic dac_load_ready, // Latch ready
	input wire logic dac_update, // Load pulse
	input wire logic [2:0] gain_code, // Gain out
	input wire logic int_ref_enable, // Reference
	input wire logic [14:0] settings, // Image
	input wire logic running, // Stepping
	input wire logic [4:0] table_index // Index
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// The first edge after reset is the load cycle, which refuses requests.
	logic live_q;
	logic [4:0] start_idx;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
		end
	end
	always_comb begin
		case (settings[7:6])
			sine_seq_pkg::PHASE_120: start_idx = sine_seq_pkg::START_IDX_120;
			sine_seq_pkg::PHASE_240: start_idx = sine_seq_pkg::START_IDX_240;
			sine_seq_pkg::PHASE_90: start_idx = sine_seq_pkg::START_IDX_90;
			default: start_idx = sine_seq_pkg::START_IDX_0;
		endcase
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_cfg;
		live_q && cfg_wr |=> settings == $past({cfg_waveform_select, cfg_step_interval,
			cfg_start_phase_select, cfg_output_gain_select, cfg_trigger_pin_setup,
			cfg_serial_out_enable});
	endproperty
	a_cfg: assert property (p_cfg) else $error("settings not taken");
	property p_store;
		live_q && nvm_store_trigger |=> nvm_wr_en && nvm_wr_data == $past(settings);
	endproperty
	a_store: assert property (p_store) else $error("store image wrong");
	property p_index;
		table_index <= sine_seq_pkg::TABLE_LAST;
	endproperty
	a_index: assert property (p_index) else $error("index past table end");
	property p_wrap;
		running && table_index == 5'h17 ##1 running && table_index != 5'h17
			|-> table_index == 5'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("index did not wrap to zero");
	property p_start;
		$rose(running) |-> table_index == start_idx;
	endproperty
	a_start: assert property (p_start) else $error("wrong start index");
	property p_ref;
		int_ref_enable == (gain_code inside {[3'h2:3'h5]});
	endproperty
	a_ref: assert property (p_ref) else $error("reference select wrong");
	property p_gain;
		settings[5:3] < 3'h6 && $stable(settings) |-> gain_code == settings[5:3];
	endproperty
	a_gain: assert property (p_gain) else $error("gain code wrong");
	property p_update;
		dac_update |-> $past(dac_load_ready);
	endproperty
	a_update: assert property (p_update) else $error("load without ready");
	property p_stop;
		(settings[2:1] == sine_seq_pkg::TRIG_START_STOP && !settings[0]
			&& !trigger_input) [*4] |-> !running;
	endproperty
	a_stop: assert property (p_stop) else $error("low pin did not halt");
	c_start: cover property ($rose(running));
	c_wrap: cover property (running && table_index == 5'h17 ##1 table_index == 5'h00);
	c_store: cover property (nvm_wr_en);
endmodule
bind sine_wave_code_sequencer seq_checker chk (.mclk, .rst_n, .cfg_wr, .cfg_waveform_select,
	.cfg_step_interval, .cfg_start_phase_select, .cfg_output_gain_select,
	.cfg_trigger_pin_setup, .cfg_serial_out_enable, .nvm_store_trigger, .nvm_wr_en,
	.nvm_wr_data, .trigger_input, .dac_load_ready, .dac_update, .gain_code,
	.int_ref_enable, .settings, .running, .table_index);

// *** tb/nvm_image_store.sv ***
`timescale 1ns/100ps
module nvm_image_store (
	input wire logic mclk, // Clock
	input wire logic nvm_wr_en, // Store pulse
	input wire logic [14:0] nvm_wr_data, // Image to store
	output logic nvm_programmed, // Image valid
	output logic [14:0] nvm_rd_data // Stored image
);
	// Cells survive reset, so nothing here looks at rst_n.
	logic [14:0] cells = 15'h2aaa;
	logic prog_q = 1'b0;
	always @(posedge mclk) begin
		if (nvm_wr_en) begin
			cells <= nvm_wr_data;
			prog_q <= 1'b1;
		end
	end
	assign nvm_programmed = prog_q;
	// Blank cells read as noise, so the device must not trust them.
	assign nvm_rd_data = nvm_programmed ? cells : ~cells;
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_wr = 1'b0;
	logic [14:0] cfg = 15'h0001;
	logic store = 1'b0;
	logic pin = 1'b0;
	logic ready = 1'b1;
	logic nvm_wr_en, nvm_programmed, dac_update, int_ref_enable, running;
	logic [14:0] nvm_wr_data, nvm_rd_data, settings, img;
	logic [11:0] dac_code, code;
	logic [2:0] gain_code;
	logic [4:0] table_index;
	logic [11:0] tab [24] = '{12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f,
		12'he66, 12'he2f, 12'hd8b, 12'hc87, 12'hb33, 12'h9a8, 12'h800, 12'h658, 12'h4cd,
		12'h379, 12'h275, 12'h1d1, 12'h19a, 12'h1d1, 12'h275, 12'h379, 12'h4cd, 12'h658};
	logic [4:0] sidx [4] = '{5'h00, 5'h08, 5'h10, 5'h06};
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	int gap;
	initial forever #2.5 mclk = ~mclk;
	sine_wave_code_sequencer dut (.mclk, .rst_n, .cfg_wr, .cfg_waveform_select(cfg[14:12]),
		.cfg_step_interval(cfg[11:8]), .cfg_start_phase_select(cfg[7:6]),
		.cfg_output_gain_select(cfg[5:3]), .cfg_trigger_pin_setup(cfg[2:1]),
		.cfg_serial_out_enable(cfg[0]), .nvm_store_trigger(store), .nvm_programmed,
		.nvm_rd_data, .nvm_wr_en, .nvm_wr_data, .trigger_input(pin), .dac_load_ready(ready),
		.dac_code, .dac_update, .gain_code, .int_ref_enable, .settings, .running,
		.table_index);
	nvm_image_store nvm (.mclk, .nvm_wr_en, .nvm_wr_data, .nvm_programmed, .nvm_rd_data);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected code at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cfg_write(input logic [14:0] v);
		@(negedge mclk);
		cfg = v;
		cfg_wr = 1'b1;
		@(negedge mclk);
		cfg_wr = 1'b0;
	endtask
	// Returns the next loaded code and the cycles waited for it.
	task automatic next_code();
		gap = 0;
		do begin
			@(negedge mclk);
			gap++;
		end while (dac_update !== 1'b1 && gap < 2000);
		chk_word(dac_update, 1'b1);
		code = dac_code;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(negedge mclk);
		chk_word(settings, 15'h0001);
		chk_code(dac_code, 12'h800);
		rst_n = 1'b1;
		repeat (3) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			cfg_write({3'(i), 4'h0, 2'h0, 3'(i), 2'h0, 1'b0});
			repeat (3) @(negedge mclk);
			chk_word(running, i == 4);
			chk_word(gain_code, (i < 6) ? i : 0);
			chk_word(int_ref_enable, i >= 2 && i <= 5);
		end
		for (int p = 0; p < 4; p++) begin
			img = {3'h4, (p == 2) ? 4'h1 : 4'h0, 2'(p), 3'h0, 2'h0, 1'b0};
			cfg_write(img);
			chk_word(settings, img);
			for (int k = 0; k < ((p == 2) ? 10 : 3); k++) begin
				next_code();
				chk_code(code, tab[(sidx[p] + k) % 24]);
				if (k > 0) chk_word(gap, (p == 2) ? 400 : 200);
			end
			cfg_write(15'h0000);
		end
		cfg_write({3'h4, 4'h0, 2'h0, 3'h0, 2'h0, 1'b0});
		ready = 1'b0;
		repeat (1200) @(negedge mclk);
		ready = 1'b1;
		for (int k = 0; k < 5; k++) begin
			next_code();
			chk_code(code, tab[k]);
			if (k < 4) chk_word(gap, 1);
		end
		cfg_write({3'h4, 4'h0, 2'h3, 3'h0, 2'h1, 1'b0});
		repeat (20) @(negedge mclk);
		chk_word(running, 0);
		chk_code(dac_code, 12'he66);
		pin = 1'b1;
		next_code();
		chk_code(code, 12'he66);
		next_code();
		chk_code(code, 12'he2f);
		pin = 1'b0;
		repeat (8) @(negedge mclk);
		chk_word(running, 0);
		chk_code(dac_code, 12'he66);
		cfg_write({3'h4, 4'h0, 2'h3, 3'h0, 2'h1, 1'b1});
		repeat (4) @(negedge mclk);
		chk_word(running, 1);
		img = {3'h4, 4'h2, 2'h1, 3'h3, 2'h0, 1'b0};
		cfg_write(img);
		store = 1'b1;
		@(negedge mclk);
		store = 1'b0;
		chk_word(nvm_wr_en, 1);
		chk_word(nvm_wr_data, img);
		// The store pulse must reach the cells before reset clears it.
		@(negedge mclk);
		rst_n = 1'b0;
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		repeat (3) @(negedge mclk);
		chk_word(settings, img);
		next_code();
		chk_code(code, tab[8]);
		tally_and_finish();
	end
endmodule
